//--- tap_defs.svh
/*
 * constants of the test-port instruction layer: lengths, instruction codes,
 * identification value and reset values.
 * assumes inclusion by bare name from the package and the bench.
 */
`ifndef TAP_DEFS_SVH
`define TAP_DEFS_SVH

// register lengths
`define IR_LEN              5
`define ID_LEN              32
`define CFG_LEN             109
`define CONV_LEN            8

// instruction codes
`define OP_EXTEST           5'h00
`define OP_SELECT_CONFIG    5'h01
`define OP_CONFIG_ERASE     5'h02
`define OP_READ_CONFIG      5'h03
`define OP_WRITE_CONFIG     5'h04
`define OP_IDCODE           5'h0D
`define OP_START_AUTOCAL    5'h10
`define OP_CONV_ERASE       5'h11
`define OP_READ_CONV        5'h12
`define OP_WRITE_CONV       5'h13
`define OP_SELECT_CONV      5'h14
`define OP_SAMPLE           5'h1E
`define OP_BYPASS           5'h1F

// identification word, value arbitrary (bit 0 set as the scan standard asks)
`define ID_VALUE            32'h0ABC_D001

// reset values
`define CFG_RESET           109'h0
`define CONV_RESET          8'h00
`define BYPASS_RESET        1'b0
`define TDO_RESET           1'b0

`endif

//--- tap_pkg.sv
/*
 * types of the test-port instruction layer: controller states, data paths
 * and the instruction decoder.
 * assumes tap_defs.svh is on the include path.
 */
package tap_pkg;
`include "tap_defs.svh"

   typedef logic [`IR_LEN-1:0] instr_t;

   typedef enum logic [3:0] {
      TEST_RESET, RUN_IDLE,
      SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPDATE_DR,
      SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPDATE_IR
   } tap_state_t;

   typedef enum logic [1:0] {
      PATH_BYPASS, PATH_ID, PATH_CONFIG, PATH_CONV
   } dr_path_t;

   // data path selected by an instruction; unlisted codes fall to bypass
   function automatic dr_path_t decode_path(input instr_t op);
      dr_path_t p;
      p = PATH_BYPASS;
      unique case (op)
         `OP_IDCODE        : p = PATH_ID;
         `OP_SELECT_CONFIG : p = PATH_CONFIG;
         `OP_SELECT_CONV   : p = PATH_CONV;
         default           : p = PATH_BYPASS;
      endcase
      return p;
   endfunction

endpackage

//--- tap_pin_sync.sv
/*
 * three-stage synchroniser for the test-port pins with agreement filter.
 * assumes asynchronous pin levels and a synchronous active-high reset.
 */
`timescale 1ns/10ps
module tap_pin_sync (
   input  wire logic       ref_clk,
   input  wire logic       sys_rst,
   input  wire logic       clk_en,
   input  wire logic [2:0] pin_in,
   output logic      [2:0] pin_level
);

   logic [2:0] stage1;
   logic [2:0] stage2;
   logic [2:0] stage3;
   logic [2:0] next_level;

   ////////////////////////////////////////////////////////////////////////////
   // a bit changes only once stage two and three agree
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         next_level[i] = (stage2[i] == stage3[i]) ? stage3[i] : pin_level[i];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         stage1    <= 3'h0;
         stage2    <= 3'h0;
         stage3    <= 3'h0;
         pin_level <= 3'h0;
      end else if (clk_en) begin
         stage1    <= pin_in;
         stage2    <= stage1;
         stage3    <= stage2;
         pin_level <= next_level;
      end
   end

endmodule

//--- nv_cfg_store.sv
/*
 * nonvolatile store model for the configuration and converter words.
 * writes only set bits, erase clears all; read data come from registers.
 * assumes one-cycle command pulses from the instruction layer.
 */
`timescale 1ns/10ps
module nv_cfg_store
   import tap_pkg::*;
(
   input  wire logic                 ref_clk,
   input  wire logic                 sys_rst,
   input  wire logic                 clk_en,
   input  wire logic                 cfg_write,
   input  wire logic                 cfg_erase,
   input  wire logic [`CFG_LEN-1:0]  cfg_wdata,
   input  wire logic                 conv_write,
   input  wire logic                 conv_erase,
   input  wire logic [`CONV_LEN-1:0] conv_wdata,
   output logic      [`CFG_LEN-1:0]  cfg_rdata,
   output logic      [`CONV_LEN-1:0] conv_rdata
);

   logic [`CFG_LEN-1:0]  next_cfg;
   logic [`CONV_LEN-1:0] next_conv;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_cfg  = cfg_rdata;
      next_conv = conv_rdata;
      if (cfg_erase) begin
         next_cfg = `CFG_RESET;
      end else if (cfg_write) begin
         next_cfg = cfg_rdata | cfg_wdata;
      end
      if (conv_erase) begin
         next_conv = `CONV_RESET;
      end else if (conv_write) begin
         next_conv = conv_rdata | conv_wdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cfg_rdata  <= `CFG_RESET;
         conv_rdata <= `CONV_RESET;
      end else if (clk_en) begin
         cfg_rdata  <= next_cfg;
         conv_rdata <= next_conv;
      end
   end

endmodule

//--- tap_config_instruction_decoder.sv
/*
 * test-port instruction layer: controller, instruction register, data paths,
 * run-idle operations (program, erase, read back, calibration).
 * assumes test clock, mode and data pins arrive asynchronously to ref_clk,
 * and cal_done comes from analog logic on ref_clk.
 */
`timescale 1ns/10ps
// Operation
// - five-bit instruction register shifted in scans
// - all-ones code selects one-bit bypass
// - sample code behaves as bypass
// - all-zeros external test behaves as bypass
// - identification code selects 32-bit identification register
// - after reset data scan reads identification
// - select-config routes scans through configuration register
// - configuration shift register is 109 bits
// - write-config commits, suspends operation while programming
// - programming starts on entry to run-idle
// - read-back loads configuration; controller then shifts out
// - select-converter routes scans through converter register
// - write-converter commits converter register
// - read-back and bulk erase for converter
// - calibration starts at run-idle, outputs zero
// - calibration finishes without further test clocking
// - bulk erase clears configuration, outputs to reference
// - programming only sets bits; erase first
// - select codes in update, operations in run-idle
// - capture-ir loads identification instruction
// - sample inputs rising, drive output falling
// - mode high five clocks reaches reset
module tap_config_instruction_decoder
   import tap_pkg::*;
(
   input  wire logic                 ref_clk,
   input  wire logic                 sys_rst,
   input  wire logic                 clk_en,
   input  wire logic                 tck_pin,
   input  wire logic                 tms_pin,
   input  wire logic                 tdi_pin,
   input  wire logic                 cal_done,
   output logic                      tdo_out,
   output logic                      tdo_oe,
   output logic      [`CFG_LEN-1:0]  config_word,
   output logic      [`CONV_LEN-1:0] converter_word,
   output logic                      op_suspend,
   output logic                      cal_active,
   output logic                      outputs_to_zero,
   output logic                      outputs_to_ref,
   output logic                      inputs_disconnect
);

   logic [2:0]           pin_level;
   logic                 tck_s;
   logic                 tms_s;
   logic                 tdi_s;
   logic                 tck_q;
   logic                 tck_rise;
   logic                 tck_fall;

   tap_state_t           state;
   tap_state_t           next_state;
   instr_t               instr;
   instr_t               next_instr;
   instr_t               ir_shift;
   instr_t               next_ir_shift;
   logic                 bypass_bit;
   logic                 next_bypass_bit;
   logic [`ID_LEN-1:0]   id_shift;
   logic [`ID_LEN-1:0]   next_id_shift;
   logic [`CFG_LEN-1:0]  cfg_shift;
   logic [`CFG_LEN-1:0]  next_cfg_shift;
   logic [`CONV_LEN-1:0] conv_shift;
   logic [`CONV_LEN-1:0] next_conv_shift;
   logic                 next_tdo_out;
   logic                 next_tdo_oe;

   logic                 rti_entry;
   logic                 cfg_write;
   logic                 cfg_erase;
   logic                 conv_write;
   logic                 conv_erase;
   logic                 next_cal_active;
   logic                 erased;
   logic                 next_erased;
   logic                 next_op_suspend;
   dr_path_t             path;
   logic                 dr_out;

   ////////////////////////////////////////////////////////////////////////////
   // codes whose run-idle operation suspends normal operation
   function automatic logic suspends_operation(input instr_t op);
      logic hit;
      hit = 1'b0;
      unique case (op)
         `OP_WRITE_CONFIG, `OP_CONFIG_ERASE,
         `OP_WRITE_CONV, `OP_CONV_ERASE : hit = 1'b1;
         default                        : hit = 1'b0;
      endcase
      return hit;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers and test clock edges
   tap_pin_sync pin_sync (
      .ref_clk   (ref_clk),
      .sys_rst   (sys_rst),
      .clk_en    (clk_en),
      .pin_in    ({tdi_pin, tms_pin, tck_pin}),
      .pin_level (pin_level)
   );

   assign tck_s    = pin_level[0];
   assign tms_s    = pin_level[1];
   assign tdi_s    = pin_level[2];
   assign tck_rise = tck_s & ~tck_q;
   assign tck_fall = ~tck_s & tck_q;

   ////////////////////////////////////////////////////////////////////////////
   // nonvolatile store
   nv_cfg_store store (
      .ref_clk    (ref_clk),
      .sys_rst    (sys_rst),
      .clk_en     (clk_en),
      .cfg_write  (cfg_write),
      .cfg_erase  (cfg_erase),
      .cfg_wdata  (cfg_shift),
      .conv_write (conv_write),
      .conv_erase (conv_erase),
      .conv_wdata (conv_shift),
      .cfg_rdata  (config_word),
      .conv_rdata (converter_word)
   );

   ////////////////////////////////////////////////////////////////////////////
   // operations started on entry to run-idle
   assign path      = decode_path(instr);
   assign rti_entry = tck_rise && !tms_s
                      && (state == UPDATE_IR || state == UPDATE_DR);
   assign cfg_write  = rti_entry && (instr == `OP_WRITE_CONFIG);
   assign cfg_erase  = rti_entry && (instr == `OP_CONFIG_ERASE);
   assign conv_write = rti_entry && (instr == `OP_WRITE_CONV);
   assign conv_erase = rti_entry && (instr == `OP_CONV_ERASE);

   ////////////////////////////////////////////////////////////////////////////
   // controller state and scan registers
   always_comb begin
      next_state      = state;
      next_instr      = instr;
      next_ir_shift   = ir_shift;
      next_bypass_bit = bypass_bit;
      next_id_shift   = id_shift;
      next_cfg_shift  = cfg_shift;
      next_conv_shift = conv_shift;
      if (tck_rise) begin
         unique case (state)
            TEST_RESET : next_state = tms_s ? TEST_RESET : RUN_IDLE;
            RUN_IDLE   : next_state = tms_s ? SEL_DR : RUN_IDLE;
            SEL_DR     : next_state = tms_s ? SEL_IR : CAP_DR;
            CAP_DR     : next_state = tms_s ? EXIT1_DR : SHIFT_DR;
            SHIFT_DR   : next_state = tms_s ? EXIT1_DR : SHIFT_DR;
            EXIT1_DR   : next_state = tms_s ? UPDATE_DR : PAUSE_DR;
            PAUSE_DR   : next_state = tms_s ? EXIT2_DR : PAUSE_DR;
            EXIT2_DR   : next_state = tms_s ? UPDATE_DR : SHIFT_DR;
            UPDATE_DR  : next_state = tms_s ? SEL_DR : RUN_IDLE;
            SEL_IR     : next_state = tms_s ? TEST_RESET : CAP_IR;
            CAP_IR     : next_state = tms_s ? EXIT1_IR : SHIFT_IR;
            SHIFT_IR   : next_state = tms_s ? EXIT1_IR : SHIFT_IR;
            EXIT1_IR   : next_state = tms_s ? UPDATE_IR : PAUSE_IR;
            PAUSE_IR   : next_state = tms_s ? EXIT2_IR : PAUSE_IR;
            EXIT2_IR   : next_state = tms_s ? UPDATE_IR : SHIFT_IR;
            UPDATE_IR  : next_state = tms_s ? SEL_DR : RUN_IDLE;
         endcase
         unique case (state)
            TEST_RESET : next_instr = `OP_IDCODE;
            CAP_IR     : next_ir_shift = `OP_IDCODE;
            SHIFT_IR   : next_ir_shift = {tdi_s, ir_shift[`IR_LEN-1:1]};
            EXIT1_IR, EXIT2_IR : begin
               // instruction takes effect on entry to update-ir
               if (tms_s) begin
                  next_instr = ir_shift;
               end
            end
            CAP_DR : begin
               unique case (path)
                  PATH_BYPASS : next_bypass_bit = `BYPASS_RESET;
                  PATH_ID     : next_id_shift = `ID_VALUE;
                  PATH_CONFIG : next_cfg_shift = cfg_shift;
                  PATH_CONV   : next_conv_shift = conv_shift;
               endcase
            end
            SHIFT_DR : begin
               unique case (path)
                  PATH_BYPASS : next_bypass_bit = tdi_s;
                  PATH_ID     : next_id_shift = {tdi_s, id_shift[`ID_LEN-1:1]};
                  PATH_CONFIG : next_cfg_shift = {tdi_s, cfg_shift[`CFG_LEN-1:1]};
                  PATH_CONV   : next_conv_shift = {tdi_s, conv_shift[`CONV_LEN-1:1]};
               endcase
            end
            default : begin
            end
         endcase
         if (rti_entry && instr == `OP_READ_CONFIG) begin
            next_cfg_shift = config_word;
         end
         if (rti_entry && instr == `OP_READ_CONV) begin
            next_conv_shift = converter_word;
         end
      end
   end

   always_comb begin
      unique case (path)
         PATH_BYPASS : dr_out = bypass_bit;
         PATH_ID     : dr_out = id_shift[0];
         PATH_CONFIG : dr_out = cfg_shift[0];
         PATH_CONV   : dr_out = conv_shift[0];
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // serial output, launched on the test clock fall
   always_comb begin
      next_tdo_out = tdo_out;
      next_tdo_oe  = tdo_oe;
      if (tck_fall) begin
         next_tdo_oe  = (state == SHIFT_DR) || (state == SHIFT_IR);
         next_tdo_out = (state == SHIFT_IR) ? ir_shift[0] : dr_out;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         tdo_out <= `TDO_RESET;
         tdo_oe  <= 1'b0;
      end else if (clk_en) begin
         tdo_out <= next_tdo_out;
         tdo_oe  <= next_tdo_oe;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         tck_q      <= 1'b0;
         state      <= TEST_RESET;
         instr      <= `OP_IDCODE;
         ir_shift   <= `OP_IDCODE;
         bypass_bit <= `BYPASS_RESET;
         id_shift   <= `ID_VALUE;
         cfg_shift  <= `CFG_RESET;
         conv_shift <= `CONV_RESET;
      end else if (clk_en) begin
         tck_q      <= tck_s;
         state      <= next_state;
         instr      <= next_instr;
         ir_shift   <= next_ir_shift;
         bypass_bit <= next_bypass_bit;
         id_shift   <= next_id_shift;
         cfg_shift  <= next_cfg_shift;
         conv_shift <= next_conv_shift;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // calibration, erase state and operation suspend
   always_comb begin
      next_cal_active = cal_active;
      next_erased     = erased;
      if (cal_active && cal_done) begin
         next_cal_active = 1'b0;
      end
      if (rti_entry && instr == `OP_START_AUTOCAL) begin
         next_cal_active = 1'b1;
      end
      if (cfg_write) begin
         next_erased = 1'b0;
      end
      if (cfg_erase) begin
         next_erased = 1'b1;
      end
      next_op_suspend = (next_state == RUN_IDLE)
                        && suspends_operation(instr);
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cal_active <= 1'b0;
         erased     <= 1'b0;
         op_suspend <= 1'b0;
      end else if (clk_en) begin
         cal_active <= next_cal_active;
         erased     <= next_erased;
         op_suspend <= next_op_suspend;
      end
   end

   assign outputs_to_zero   = cal_active;
   assign outputs_to_ref    = erased && !cal_active;
   assign inputs_disconnect = erased;

endmodule

//--- tap_config_instruction_decoder_properties.sv
/* port assertions of the test-port instruction layer.
   assumes one ref_clk domain and a synchronous active-high sys_rst. */
`timescale 1ns/10ps
module tap_checker (
   input wire logic         ref_clk,
   input wire logic         sys_rst,
   input wire logic         tck_pin,
   input wire logic         tms_pin,
   input wire logic         cal_done,
   input wire logic         tdo_out,
   input wire logic         tdo_oe,
   input wire logic [108:0] config_word,
   input wire logic [7:0]   converter_word,
   input wire logic         op_suspend,
   input wire logic         cal_active,
   input wire logic         outputs_to_zero,
   input wire logic         outputs_to_ref,
   input wire logic         inputs_disconnect
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////
   // rise with mode low: entry into run-idle
   sequence s_idle_entry;
      !$past(tms_pin, 2);
   endsequence
   a_zero_in_cal: assert property (outputs_to_zero == cal_active)
      else $error("outputs_to_zero not equal to cal_active");
   a_ref_after_erase: assert property (
      outputs_to_ref == (inputs_disconnect && !cal_active))
      else $error("outputs_to_ref wrong");
   a_erase_clears_config: assert property (
      !$past(sys_rst) && $rose(inputs_disconnect) |-> config_word == '0)
      else $error("configuration not cleared by erase");
   a_cal_holds: assert property (cal_active && !cal_done |=> cal_active)
      else $error("calibration ended without done");
   a_cal_ends: assert property (
      !$past(sys_rst) && $fell(cal_active) |-> $past(cal_done))
      else $error("calibration ended without done");
   a_cal_on_entry: assert property ($rose(cal_active) |-> s_idle_entry)
      else $error("calibration started outside run-idle entry");
   a_suspend_on_entry: assert property ($rose(op_suspend) |-> s_idle_entry)
      else $error("suspend started outside run-idle entry");
   a_cfg_in_suspend: assert property (
      !$past(sys_rst) && $changed(config_word) |-> op_suspend || $past(op_suspend))
      else $error("configuration changed without suspend");
   a_conv_on_entry: assert property (
      !$past(sys_rst) && $changed(converter_word) |-> !$past(tms_pin, 3))
      else $error("converter changed outside run-idle entry");
   a_tdo_on_fall: assert property (
      !$past(sys_rst) && ($changed(tdo_out) || $changed(tdo_oe)) |-> !$past(tck_pin, 2))
      else $error("serial output changed while test clock high");
endmodule
bind tap_config_instruction_decoder tap_checker i_chk (
   .ref_clk(ref_clk), .sys_rst(sys_rst), .tck_pin(tck_pin), .tms_pin(tms_pin),
   .cal_done(cal_done), .tdo_out(tdo_out), .tdo_oe(tdo_oe), .config_word(config_word),
   .converter_word(converter_word), .op_suspend(op_suspend), .cal_active(cal_active),
   .outputs_to_zero(outputs_to_zero), .outputs_to_ref(outputs_to_ref),
   .inputs_disconnect(inputs_disconnect));

//--- jtag_host.sv
/* scan controller model driving the test port, 160 ns test clock.
   assumes ref_clk at 20 ns; test clock stands low between frames. */
`timescale 1ns/10ps
module jtag_host (
   input  wire logic ref_clk,
   input  wire logic tdo_out,
   output logic      tck_pin,
   output logic      tms_pin,
   output logic      tdi_pin
);
   initial begin
      tck_pin = 1'b0;
      tms_pin = 1'b1;
      tdi_pin = 1'b0;
   end
   ////////////////////////////////////////
   // one clock: change at fall, output read before next fall
   task automatic pulse(input logic tms, input logic tdi, output logic tdo);
      @(posedge ref_clk);
      tck_pin <= 1'b0;
      tms_pin <= tms;
      tdi_pin <= tdi;
      repeat (4) @(posedge ref_clk);
      tck_pin <= 1'b1;
      repeat (3) @(posedge ref_clk);
      tdo = tdo_out;
   endtask
   task automatic park();
      @(posedge ref_clk);
      tck_pin <= 1'b0;
      tdi_pin <= ~tdi_pin;
   endtask
   task automatic go_reset();
      logic t;
      repeat (5) pulse(1'b1, 1'b0, t);
      pulse(1'b0, 1'b0, t);
      park();
   endtask
   // scan from run-idle, back to run-idle, then n_idle clocks
   task automatic scan(input logic ir, input int len, input logic [127:0] din,
                       output logic [127:0] dout, input int n_idle);
      logic t;
      dout = 128'h0;
      pulse(1'b1, 1'b0, t);
      if (ir) pulse(1'b1, 1'b0, t);
      pulse(1'b0, 1'b0, t);
      pulse(1'b0, 1'b0, t);
      for (int i = 0; i < len; i++) pulse(i == len - 1, din[i], dout[i]);
      pulse(1'b1, 1'b0, t);
      pulse(1'b0, 1'b0, t);
      repeat (n_idle) pulse(1'b0, 1'b0, t);
      park();
   endtask
endmodule

//--- tb_top.sv
/* self-checking bench of the test-port instruction layer.
   assumes jtag_host as controller and the checker bound in its own file. */
`timescale 1ns/10ps
`include "tap_defs.svh"
`define CHECK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
   $display("wrong value at %0t: %0h expected %0h", $time, (a), (b)); end end
module tb_top
   import tap_pkg::*;
;
   localparam logic [108:0] P1 = {1'b1, {27{4'h5}}};
   localparam logic [108:0] P2 = {1'b0, {27{4'hC}}};
   logic         ref_clk, sys_rst, clk_en, tck_pin, tms_pin, tdi_pin, cal_done;
   logic         tdo_out, tdo_oe, op_suspend, cal_active;
   logic         outputs_to_zero, outputs_to_ref, inputs_disconnect;
   logic [108:0] config_word;
   logic [7:0]   converter_word;
   logic [127:0] d;
   int           n_mismatch = 0;
   int           n_tests = 0;
   tap_config_instruction_decoder i_dut (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en), .tck_pin(tck_pin),
      .tms_pin(tms_pin), .tdi_pin(tdi_pin), .cal_done(cal_done), .tdo_out(tdo_out),
      .tdo_oe(tdo_oe), .config_word(config_word), .converter_word(converter_word),
      .op_suspend(op_suspend), .cal_active(cal_active), .outputs_to_zero(outputs_to_zero),
      .outputs_to_ref(outputs_to_ref), .inputs_disconnect(inputs_disconnect));
   jtag_host i_host (.ref_clk(ref_clk), .tdo_out(tdo_out), .tck_pin(tck_pin),
      .tms_pin(tms_pin), .tdi_pin(tdi_pin));
   ////////////////////////////////////////
   task automatic load_ir(input instr_t op, input int n_idle);
      i_host.scan(1'b1, 5, {123'h0, op}, d, n_idle);
      `CHECK(d[4:0], `OP_IDCODE)
   endtask
   task automatic dr(input int len, input logic [127:0] din);
      i_host.scan(1'b0, len, din, d, 2);
   endtask
   task automatic t_reset_id();
      i_host.go_reset();
      dr(32, 128'h0);
      `CHECK(d[31:0], `ID_VALUE)
      load_ir(`OP_BYPASS, 2);
      load_ir(`OP_IDCODE, 2);
      dr(32, 128'h0);
      `CHECK(d[31:0], `ID_VALUE)
   endtask
   task automatic t_bypass();
      instr_t ops [4] = '{`OP_BYPASS, `OP_SAMPLE, `OP_EXTEST, 5'h07};
      for (int k = 0; k < 4; k++) begin
         load_ir(ops[k], 2);
         dr(3, 128'h5);
         `CHECK(d[2:0], 3'b010)
      end
   endtask
   task automatic t_config();
      load_ir(`OP_SELECT_CONFIG, 2);
      dr(109, {19'h0, P1});
      load_ir(`OP_WRITE_CONFIG, 2);
      `CHECK(config_word, P1)
      load_ir(`OP_SELECT_CONFIG, 2);
      dr(109, {19'h0, P2});
      `CHECK(d[108:0], P1)
      `CHECK(config_word, P1)
      load_ir(`OP_WRITE_CONFIG, 2);
      `CHECK(config_word, P1 | P2)
      load_ir(`OP_CONFIG_ERASE, 2);
      `CHECK(config_word, 109'h0)
      `CHECK({inputs_disconnect, outputs_to_ref, op_suspend, tdo_oe}, 4'b1110)
      load_ir(`OP_WRITE_CONFIG, 2);
      `CHECK({config_word, inputs_disconnect}, {P2, 1'b0})
      load_ir(`OP_SELECT_CONFIG, 2);
      dr(109, 128'h0);
      load_ir(`OP_READ_CONFIG, 2);
      load_ir(`OP_SELECT_CONFIG, 2);
      dr(109, 128'h0);
      `CHECK(d[108:0], P2)
   endtask
   task automatic t_conv();
      load_ir(`OP_SELECT_CONV, 2);
      dr(8, 128'hA5);
      load_ir(`OP_WRITE_CONV, 2);
      `CHECK(converter_word, 8'hA5)
      load_ir(`OP_SELECT_CONV, 2);
      dr(8, 128'h0F);
      `CHECK(d[7:0], 8'hA5)
      load_ir(`OP_WRITE_CONV, 2);
      `CHECK(converter_word, 8'hAF)
      load_ir(`OP_CONV_ERASE, 2);
      `CHECK(converter_word, 8'h00)
      load_ir(`OP_READ_CONV, 2);
      load_ir(`OP_SELECT_CONV, 2);
      dr(8, 128'h0);
      `CHECK(d[7:0], 8'h00)
   endtask
   task automatic t_cal();
      load_ir(`OP_START_AUTOCAL, 0);
      repeat (8) @(posedge ref_clk);
      `CHECK({cal_active, outputs_to_zero}, 2'b11)
      i_host.go_reset();
      `CHECK(cal_active, 1'b1)
      clk_en <= 1'b0;
      cal_done <= 1'b1;
      repeat (2) @(posedge ref_clk);
      `CHECK(cal_active, 1'b1)
      clk_en <= 1'b1;
      @(posedge ref_clk);
      cal_done <= 1'b0;
      repeat (3) @(posedge ref_clk);
      `CHECK({cal_active, outputs_to_zero}, 2'b00)
   endtask
   task automatic final_report();
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   initial begin
      sys_rst = 1'b1;
      clk_en = 1'b1;
      cal_done = 1'b0;
      repeat (3) @(posedge ref_clk);
      sys_rst <= 1'b0;
      t_reset_id();
      t_bypass();
      t_config();
      t_conv();
      t_cal();
      i_host.go_reset();
      final_report();
   end
   initial begin
      repeat (60000) @(posedge ref_clk);
      n_mismatch++;
      final_report();
   end
endmodule
